/* File: i2c_ctrl_status.sv */
// Enable, read-to-clear and status registers of the two-wire bus controller
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "i2c_status_map.svh"

// What this block does
// - Reading clear register drops receive overflow flag
// - Reading clear register drops transmit overflow flag
// - Reading clear register drops read request flag
// - Abort clear read drops flag and cause
// - Abort clear read releases held transmit flush
// - Reading clear register drops transmit done flag
// - Activity clear read returns flag, clears if idle
// - Activity flag self-clears when disabled and idle
// - Reading clear register drops stop seen flag
// - Reading clear register drops start seen flag
// - Reading clear register drops general call flag
// - Abort bit settable only when enabled
// - Abort ends transfer, flushes, flags, self-clears
// - Disabled controller flushes and holds both queues
// - Flags stay until state machines idle
// - Disable while sending finishes transfer, discards rest
// - Disable while receiving stops, no acknowledge
// - Enable change takes effect two cycles later
// - Disabled status shows empty transmit, empty receive
// - Disabled idle machines read inactive
// - Activity bits follow state machines, bit0 ORs
// - Status queue bits track queues, no interrupt
// - Start-byte cause bit reasserts after one cycle while sbyte_cond holds
module i2c_ctrl_status
(
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic [31:0]                addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [31:0]                     rdata,
  input  wire logic                       scl_in,
  input  wire logic [11:0]                event_set,
  input  wire logic [16:0]                cause_set,
  input  wire logic                       sbyte_cond,
  input  wire logic                       abort_done,
  input  wire logic                       master_fsm_busy,
  input  wire logic                       slave_fsm_busy,
  input  wire logic                       receiving,
  input  wire i2c_status_pkg::fifo_state_t fifo,
  output logic                            controller_on_level,
  output logic                            abort_request,
  output logic                            tx_flush,
  output logic                            rx_flush,
  output logic                            stop_after_transfer,
  output logic                            nack_last_byte,
  output logic [11:0]                     raw_interrupt_status,
  output logic [16:0]                     abort_cause_register
);
  import i2c_status_pkg::*;

  logic     rst_m_b;
  logic     rst_s_b;
  state_t   s_q;
  state_t   s_d;
  bus_req_t req;
  logic     busy;
  logic     scl_fall;
  logic     abort_clr;
  logic [11:0] clr_mask;
  logic [11:0] ev_all;

  // Clear mask for a read at the given address
  function automatic logic [11:0] clear_of(input logic [31:0] a, input logic act);
    logic [11:0] m;
    m = 12'h000;
    case (a)
      `OFS_CLR_RX_OVER:  m[`BIT_RX_OVER] = 1'b1;
      `OFS_CLR_TX_OVER:  m[`BIT_TX_OVER] = 1'b1;
      `OFS_CLR_RD_REQ:   m[`BIT_RD_REQ] = 1'b1;
      `OFS_CLR_TX_ABORT: m[`BIT_TX_ABORT] = 1'b1;
      `OFS_CLR_TX_DONE:  m[`BIT_TX_DONE] = 1'b1;
      `OFS_CLR_BUSY:     m[`BIT_BUSY] = ~act;
      `OFS_CLR_STOP:     m[`BIT_STOP] = 1'b1;
      `OFS_CLR_START:    m[`BIT_START] = 1'b1;
      `OFS_CLR_GENERAL_CALL_FLAG: m[`BIT_GENERAL_CALL_FLAG] = 1'b1;
      default:           m = 12'h000;
    endcase
    return m;
  endfunction : clear_of

  // Status word from enable, queue state and machine activity
  function automatic logic [31:0] status_of(input logic on, input fifo_state_t f,
                                            input logic mst, input logic slv);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[6] = slv;
    v[5] = mst;
    v[4] = on & f.rx_full;
    v[3] = on & f.rx_nonempty;
    v[2] = ~on | f.tx_empty;
    v[1] = ~on | ~f.tx_full;
    v[0] = slv | mst;
    return v;
  endfunction : status_of

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_b <= 1'b0;
      rst_s_b <= 1'b0;
    end
    else
    begin
      rst_m_b <= 1'b1;
      rst_s_b <= rst_m_b;
    end
  end

  assign req.addr = addr;
  assign req.wdata = wdata;
  assign req.wr = wr;
  assign req.rd = rd;
  assign busy = master_fsm_busy | slave_fsm_busy;
  assign scl_fall = s_q.scl_p & ~s_q.scl_s;

  always_comb
  begin
    s_d = s_q;
    s_d.scl_m = scl_in;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    clr_mask = 12'h000;
    abort_clr = 1'b0;
    ev_all = event_set;
    if (req.rd)
    begin
      clr_mask = clear_of(req.addr, busy);
      abort_clr = (req.addr == `OFS_CLR_TX_ABORT);
    end
    if (req.wr && req.addr == `OFS_ENABLE)
    begin
      s_d.en = req.wdata[`EN_BIT_ON];
      if (req.wdata[`EN_BIT_ABORT] && s_q.en)
        s_d.abort = 1'b1;
    end
    // abort finished by master, flag raised
    if (abort_done && s_q.abort)
    begin
      s_d.abort = 1'b0;
      ev_all[`BIT_TX_ABORT] = 1'b1;
    end
    if (|cause_set)
      ev_all[`BIT_TX_ABORT] = 1'b1;
    ev_all[`BIT_BUSY] = event_set[`BIT_BUSY] | busy | (scl_fall & s_q.on_pipe[1]);
    s_d.on_pipe = {s_q.on_pipe[0], s_q.en};
    s_d.raw = (s_q.raw & ~clr_mask) | ev_all;
    // hardware clear when off and idle
    if (!s_q.on_pipe[1] && !busy)
      s_d.raw = `RST_RAW;
    // abort cause cleared with the flag
    s_d.cause = (s_q.cause & ~{17{abort_clr}}) | cause_set;
    // start-byte cause drops for one cycle only while sbyte_cond stays high
    if (abort_clr)
      s_d.cause[`CAUSE_BIT_SBYTE] = 1'b0;
    else
      s_d.cause[`CAUSE_BIT_SBYTE] = s_q.cause[`CAUSE_BIT_SBYTE] | sbyte_cond
                                    | cause_set[`CAUSE_BIT_SBYTE];
    // transmit flush held until abort clear
    s_d.tx_flush = ~s_d.on_pipe[1] | s_d.raw[`BIT_TX_ABORT];
    s_d.rx_flush = ~s_d.on_pipe[1];
    s_d.stop_after = ~s_d.on_pipe[1] & busy & ~receiving;
    s_d.nack_last = ~s_d.on_pipe[1] & busy & receiving;
    s_d.rdata = 32'h0000_0000;
    if (req.rd)
    begin
      case (req.addr)
        `OFS_CLR_BUSY:    s_d.rdata[0] = s_q.raw[`BIT_BUSY];
        `OFS_ENABLE:      s_d.rdata[1:0] = {s_q.abort, s_q.en};
        `OFS_STATUS:      s_d.rdata = status_of(s_q.en, fifo, master_fsm_busy,
                                                slave_fsm_busy);
        `OFS_RAW_STATUS:  s_d.rdata[11:0] = s_q.raw;
        `OFS_ABORT_CAUSE: s_d.rdata[16:0] = s_q.cause;
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_s_b)
  begin
    if (!rst_s_b)
    begin
      s_q <= '0;
      s_q.tx_flush <= 1'b1;
      s_q.rx_flush <= 1'b1;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign controller_on_level = s_q.on_pipe[1];
  assign abort_request = s_q.abort;
  assign tx_flush = s_q.tx_flush;
  assign rx_flush = s_q.rx_flush;
  assign stop_after_transfer = s_q.stop_after;
  assign nack_last_byte = s_q.nack_last;
  assign raw_interrupt_status = s_q.raw;
  assign abort_cause_register = s_q.cause;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_s_b);

  rx_over_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_RX_OVER && !event_set[`BIT_RX_OVER]
    |=> !raw_interrupt_status[`BIT_RX_OVER])
    else $error("receive overflow flag not cleared by read");

  tx_over_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_TX_OVER && !event_set[`BIT_TX_OVER]
    |=> !raw_interrupt_status[`BIT_TX_OVER])
    else $error("transmit overflow flag not cleared by read");

  rd_req_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_RD_REQ && !event_set[`BIT_RD_REQ]
    |=> !raw_interrupt_status[`BIT_RD_REQ])
    else $error("read request flag not cleared by read");

  flush_release_a: assert property (
    clk_en && rd && addr == `OFS_CLR_TX_ABORT && controller_on_level
    && s_d.on_pipe[1] && !(|cause_set) && !abort_done && !event_set[`BIT_TX_ABORT]
    |=> !tx_flush)
    else $error("transmit flush not released by abort clear");

  abort_gate_a: assert property (
    clk_en && !s_q.en && !abort_request |=> !abort_request)
    else $error("abort request set while disabled");

  // abort completion raises flag and drops request
  abort_done_a: assert property (
    clk_en && abort_done && abort_request && controller_on_level
    |=> !abort_request && raw_interrupt_status[`BIT_TX_ABORT] && tx_flush)
    else $error("abort completion not handled");

  // enable reaches level two cycles after write
  en_delay_a: assert property (
    clk_en && wr && addr == `OFS_ENABLE ##1 clk_en [*2]
    |-> ##1 controller_on_level == $past(wdata[0], 3))
    else $error("enable level delay is not two cycles");

  off_flush_a: assert property (
    !controller_on_level |-> tx_flush && rx_flush)
    else $error("queues not flushed while disabled");

  // activity flag drops when off and idle
  busy_hw_clr_a: assert property (
    clk_en && !controller_on_level && !master_fsm_busy && !slave_fsm_busy
    |=> !raw_interrupt_status[`BIT_BUSY])
    else $error("activity flag not cleared when off and idle");

  // start-byte cause back after one cycle
  sbyte_pulse_a: assert property (
    clk_en && rd && addr == `OFS_CLR_TX_ABORT ##1 clk_en && sbyte_cond
    |-> !abort_cause_register[`CAUSE_BIT_SBYTE]
        ##1 abort_cause_register[`CAUSE_BIT_SBYTE])
    else $error("start-byte cause not reasserted after one cycle");

  status_act_a: assert property (
    clk_en && rd && addr == `OFS_STATUS
    |=> rdata[0] == (rdata[5] | rdata[6]) && rdata[5] == $past(master_fsm_busy))
    else $error("status activity bits wrong");

  status_off_a: assert property (
    clk_en && rd && addr == `OFS_STATUS && !s_q.en
    |=> rdata[4:1] == 4'h3)
    else $error("disabled status queue bits wrong");

  // writes to clear registers have no effect
  wr_no_clr_a: assert property (
    clk_en && wr && addr == `OFS_CLR_STOP && raw_interrupt_status[`BIT_STOP]
    && (controller_on_level || master_fsm_busy || slave_fsm_busy)
    |=> raw_interrupt_status[`BIT_STOP])
    else $error("write cleared a flag");

  tx_done_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_TX_DONE && !event_set[`BIT_TX_DONE]
    |=> !raw_interrupt_status[`BIT_TX_DONE])
    else $error("transmit done flag not cleared by read");

  stop_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_STOP && !event_set[`BIT_STOP]
    |=> !raw_interrupt_status[`BIT_STOP])
    else $error("stop seen flag not cleared by read");

  start_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_START && !event_set[`BIT_START]
    |=> !raw_interrupt_status[`BIT_START])
    else $error("start seen flag not cleared by read");

  general_call_flag_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_GENERAL_CALL_FLAG && !event_set[`BIT_GENERAL_CALL_FLAG]
    |=> !raw_interrupt_status[`BIT_GENERAL_CALL_FLAG])
    else $error("general call flag not cleared by read");

  // abort flag and cause cleared together
  abort_clr_a: assert property (
    clk_en && rd && addr == `OFS_CLR_TX_ABORT && !(|cause_set) && !abort_done
    && !event_set[`BIT_TX_ABORT]
    |=> !raw_interrupt_status[`BIT_TX_ABORT] && abort_cause_register == 17'h0_0000)
    else $error("abort flag or cause not cleared by read");

  busy_read_a: assert property (
    clk_en && rd && addr == `OFS_CLR_BUSY
    |=> rdata[0] == $past(raw_interrupt_status[`BIT_BUSY]) && rdata[31:1] == 31'h0)
    else $error("activity read value wrong");

  // activity kept while a machine is busy
  busy_keep_a: assert property (
    clk_en && rd && addr == `OFS_CLR_BUSY && (master_fsm_busy || slave_fsm_busy)
    |=> raw_interrupt_status[`BIT_BUSY])
    else $error("activity flag cleared while busy");

  stop_after_a: assert property (
    clk_en && (master_fsm_busy || slave_fsm_busy) && !receiving
    |=> controller_on_level || stop_after_transfer)
    else $error("stop after transfer not requested");

  nack_last_a: assert property (
    clk_en && (master_fsm_busy || slave_fsm_busy) && receiving
    |=> controller_on_level || nack_last_byte)
    else $error("last byte acknowledge not withheld");

  status_idle_a: assert property (
    clk_en && rd && addr == `OFS_STATUS && !master_fsm_busy && !slave_fsm_busy
    |=> rdata[6:5] == 2'h0 && !rdata[0])
    else $error("idle status activity bits set");

  status_queue_a: assert property (
    clk_en && rd && addr == `OFS_STATUS && s_q.en
    |=> rdata[4] == $past(fifo.rx_full) && rdata[3] == $past(fifo.rx_nonempty)
        && rdata[2] == $past(fifo.tx_empty) && rdata[1] == !$past(fifo.tx_full))
    else $error("status queue bits wrong");

  // clear registers read zero above bit 0
  clr_rsvd_a: assert property (
    clk_en && rd && addr == `OFS_CLR_STOP
    |=> rdata == 32'h0000_0000)
    else $error("clear register read not zero");

endmodule : i2c_ctrl_status

/* File: i2c_remote_model.sv */
// Remote bus party that clocks frames on the serial clock line
`timescale 1ns/1ps
module i2c_remote_model
(
  input  wire logic go,
  output logic      scl_line,
  output logic      busy
);
  initial
  begin
    scl_line = 1'b1;
    busy     = 1'b0;
  end
  // Nine clock pulses per frame; between frames the model drives the line high
  always @(posedge go)
  begin
    busy = 1'b1;
    repeat (18)
    begin
      #62.5 scl_line = ~scl_line;
    end
    #100 busy = 1'b0;
  end
endmodule : i2c_remote_model

/* File: i2c_status_map.svh */
// Register offsets, field positions and reset values of the control and status block
`ifndef I2C_STATUS_MAP_SVH
`define I2C_STATUS_MAP_SVH

`define OFS_CLR_RX_OVER   32'hB000_2848
`define OFS_CLR_TX_OVER   32'hB000_284C
`define OFS_CLR_RD_REQ    32'hB000_2850
`define OFS_CLR_TX_ABORT  32'hB000_2854
`define OFS_CLR_TX_DONE   32'hB000_2858
`define OFS_CLR_BUSY      32'hB000_285C
`define OFS_CLR_STOP      32'hB000_2860
`define OFS_CLR_START     32'hB000_2864
`define OFS_CLR_GENERAL_CALL_FLAG  32'hB000_2868
`define OFS_ENABLE        32'hB000_286C
`define OFS_STATUS        32'hB000_2870
`define OFS_RAW_STATUS    32'hB000_2878
`define OFS_ABORT_CAUSE   32'hB000_2880

`define BIT_RX_OVER       4'h1
`define BIT_TX_OVER       4'h3
`define BIT_RD_REQ        4'h5
`define BIT_TX_ABORT      4'h6
`define BIT_TX_DONE       4'h7
`define BIT_BUSY          4'h8
`define BIT_STOP          4'h9
`define BIT_START         4'hA
`define BIT_GENERAL_CALL_FLAG      4'hB

`define EN_BIT_ON         1'h0
`define EN_BIT_ABORT      1'h1
`define CAUSE_BIT_SBYTE   5'h09

`define RST_ENABLE        2'h0
`define RST_STATUS        7'h06
`define RST_RAW           12'h000
`define RST_CAUSE         17'h0_0000

`define EN_DELAY_CYCLES   2

`endif

/* File: i2c_status_pkg.sv */
// Types shared by the control and status block
package i2c_status_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_nonempty;
  } fifo_state_t;

  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        scl_p;
    logic        en;
    logic        abort;
    logic [1:0]  on_pipe;
    logic [11:0] raw;
    logic [16:0] cause;
    logic        tx_flush;
    logic        rx_flush;
    logic        stop_after;
    logic        nack_last;
    logic [31:0] rdata;
  } state_t;

endpackage : i2c_status_pkg

/* File: tb_i2c_ctrl_status.sv */
// Self-checking bench for the control and status registers
`timescale 1ns/1ps
`include "i2c_status_map.svh"
module tb_i2c_ctrl_status;
  import i2c_status_pkg::*;
  typedef struct packed {logic [31:0] ofs; logic [3:0] bitn;} row_t;
  logic        clock, rst_b, wr, rd, scl_in, go, sbyte_cond, abort_done;
  logic        mst_busy, slv_busy, receiving, on_level, abort_request;
  logic        tx_flush, rx_flush, stop_after, nack_last, clk_en;
  logic [31:0] addr, wdata, rdata, got;
  logic [11:0] event_set, raw;
  logic [16:0] cause_set, cause;
  fifo_state_t fifo;
  int          errors, check_count;
  row_t        rows [7];

  i2c_ctrl_status i2c_ctrl_status_inst (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in),
    .event_set(event_set), .cause_set(cause_set), .sbyte_cond(sbyte_cond),
    .abort_done(abort_done), .master_fsm_busy(mst_busy), .slave_fsm_busy(slv_busy),
    .receiving(receiving), .fifo(fifo), .controller_on_level(on_level),
    .abort_request(abort_request), .tx_flush(tx_flush), .rx_flush(rx_flush),
    .stop_after_transfer(stop_after), .nack_last_byte(nack_last), .raw_interrupt_status(raw),
    .abort_cause_register(cause));

  i2c_remote_model i2c_remote_model_inst (.go(go), .scl_line(scl_in), .busy(mst_busy));

  always #5 clock = ~clock;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      errors++;
    end
  endtask : chk

  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [31:0] a);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  task automatic ev(input logic [11:0] m, input logic [16:0] c);
    @(posedge clock);
    event_set <= m;
    cause_set <= c;
    @(posedge clock);
    event_set <= 12'h000;
    cause_set <= 17'h0_0000;
    #1;
  endtask : ev

  task automatic wait_idle;
    int n;
    n = 0;
    while (mst_busy !== 1'b0 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 400)
    begin
      errors++;
      results();
    end
  endtask : wait_idle

  initial
  begin
    rows = '{'{`OFS_CLR_RX_OVER, `BIT_RX_OVER}, '{`OFS_CLR_TX_OVER, `BIT_TX_OVER},
      '{`OFS_CLR_RD_REQ, `BIT_RD_REQ}, '{`OFS_CLR_TX_DONE, `BIT_TX_DONE},
      '{`OFS_CLR_STOP, `BIT_STOP}, '{`OFS_CLR_START, `BIT_START},
      '{`OFS_CLR_GENERAL_CALL_FLAG, `BIT_GENERAL_CALL_FLAG}};
    {clock, rst_b, wr, rd, go, sbyte_cond, abort_done, slv_busy, receiving} = 9'h000;
    {addr, wdata, event_set, cause_set, fifo} = 97'h0;
    clk_en = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    cyc(4);
    chk(tx_flush & rx_flush, 1);
    rd_reg(`OFS_STATUS);
    chk(got, 32'h0000_0006);
    rd_reg(32'hB000_2840);
    chk(got, 32'h0000_0000);
    wr_reg(`OFS_ENABLE, 32'h0000_0002);
    cyc(3);
    chk(abort_request, 0);
    wr_reg(`OFS_ENABLE, 32'h0000_0001);
    cyc(1);
    chk(on_level, 0);
    cyc(1);
    chk(on_level, 1);
    chk(tx_flush | rx_flush, 0);
    foreach (rows[i])
    begin
      ev(12'h001 << rows[i].bitn, 17'h0_0000);
      wr_reg(rows[i].ofs, 32'hFFFF_FFFF);
      cyc(1);
      chk(raw[rows[i].bitn], 1);
      rd_reg(rows[i].ofs);
      chk(got[31:1], 0);
      chk(raw[rows[i].bitn], 0);
    end
    wr_reg(`OFS_ENABLE, 32'h0000_0003);
    wr_reg(`OFS_ENABLE, 32'h0000_0001);
    cyc(2);
    chk(abort_request, 1);
    ev(12'h000, 17'h0_0000);
    abort_done <= 1'b1;
    @(posedge clock);
    abort_done <= 1'b0;
    cyc(2);
    chk({abort_request, raw[6], tx_flush}, 3'h3);
    sbyte_cond <= 1'b1;
    ev(12'h000, 17'h0_0208);
    chk(cause, 17'h0_0208);
    rd_reg(`OFS_CLR_TX_ABORT);
    chk({raw[6], tx_flush}, 0);
    chk(cause, 0);
    cyc(1);
    chk(cause, 17'h0_0200);
    sbyte_cond <= 1'b0;
    slv_busy <= 1'b1;
    fifo <= 4'hB;
    rd_reg(`OFS_STATUS);
    chk(got, 32'h0000_0059);
    ev(12'h002, 17'h0_0000);
    wr_reg(`OFS_ENABLE, 32'h0000_0000);
    rd_reg(`OFS_STATUS);
    chk(got, 32'h0000_0047);
    cyc(5);
    chk({raw[1], rx_flush}, 3);
    chk({stop_after, nack_last}, 2'h2);
    receiving <= 1'b1;
    cyc(2);
    chk({stop_after, nack_last}, 2'h1);
    receiving <= 1'b0;
    slv_busy <= 1'b0;
    cyc(5);
    rd_reg(`OFS_STATUS);
    chk(got, 32'h0000_0006);
    chk(raw, 0);
    wr_reg(`OFS_ENABLE, 32'h0000_0001);
    cyc(3);
    go <= 1'b1;
    cyc(30);
    go <= 1'b0;
    rd_reg(`OFS_CLR_BUSY);
    chk({got, raw[8]}, 33'h0_0000_0003);
    wait_idle();
    cyc(4);
    rd_reg(`OFS_CLR_BUSY);
    chk({got, raw[8]}, 33'h0_0000_0002);
    clk_en <= 1'b0;
    wr_reg(`OFS_ENABLE, 32'h0000_0000);
    cyc(3);
    chk(on_level, 1);
    clk_en <= 1'b1;
    cyc(3);
    chk(on_level, 1);
    results();
  end
endmodule : tb_i2c_ctrl_status
